//--- verilog/buck_regs_map.svh
// Register offsets, field positions, reset values for the buck register bank
`ifndef BUCK_REGS_MAP_SVH
`define BUCK_REGS_MAP_SVH

`define OFS_REG_A_CTRL    12'h004
`define OFS_REG_B_CTRL    12'h008
`define OFS_REG_C_CTRL    12'h00c
`define OFS_PEAK_AB       12'h014
`define OFS_PEAK_C        12'h018
`define OFS_MAX_ON        12'h01c
`define OFS_LOAD_A        12'h020
`define OFS_LOAD_B        12'h024
`define OFS_LOAD_C        12'h028
`define OFS_ALERT_A       12'h030
`define OFS_ALERT_B       12'h034
`define OFS_ALERT_C       12'h038
`define OFS_OUT_READY     12'h040
`define OFS_ZCAL_A        12'h044
`define OFS_ZCAL_B        12'h048
`define OFS_ZCAL_C        12'h04c
`define OFS_LIMIT_CFG     12'h080

`define RANGE_BIT         7
`define VSET_MSB          6
`define RST_RANGE         1'h1
`define RST_VSET_A        7'h78
`define RST_VSET_B        7'h32
`define RST_VSET_C        7'h32
`define RST_PEAK_AB       32'h0000_0088
`define RST_PEAK_C        32'h0000_0008
`define RST_MAX_ON        32'h0000_0008
`define RST_PFAIL_CODE    8'h00

`endif

//--- verilog/buck_regs_pkg.sv
// Types shared by the buck register bank
package buck_regs_pkg;
    typedef logic [7:0] ctrl_t;
    typedef enum logic [1:0] {
        ST_IDLE   = 2'b00,
        ST_ACCESS = 2'b01
    } bus_st_t;
endpackage

//--- verilog/pfail_cmp.sv
// Compares a programmed regulator setting against the rail's reset level
`timescale 1ns/1ns
module pfail_cmp (
    input  wire logic [7:0] setting,
    input  wire logic [7:0] limit,
    output logic            below
);
    // Range bit adds 10 steps of base offset; compare in 10 mV units
    logic [7:0] level;
    assign level = {1'b0, setting[6:0]} + (setting[7] ? 8'h0a : 8'h00);
    assign below = (level < limit);
endmodule

//--- verilog/buck_regulator_control_regs.sv
// APB register bank for the three-output buck supply controller
//
// Operation
// - Bit 7 selects range, resets 1
// - Bits 6:0 set voltage, 10 mV steps
// - Regulator A voltage resets to 0x78
// - Regulator B same layout, resets 0x32
// - Setting below fail level triggers rail reset
// - Controls decode at 0x04, 0x08, 0x0c
// - Read-only output ready status at 0x40
// - Supply below threshold resets its domain
//
// The APB slave port was left to the implementer.
`timescale 1ns/1ns
`include "buck_regs_map.svh"
module buck_regulator_control_regs (
    input  wire logic        CLK,
    input  wire logic        RSTN,
    input  wire logic        PSEL,
    input  wire logic        PENABLE,
    input  wire logic        PWRITE,
    input  wire logic [11:0] PADDR,
    input  wire logic [31:0] PWDATA,
    input  wire logic [3:0]  PSTRB,
    output logic      [31:0] PRDATA,
    output logic             PREADY,
    output logic             PSLVERR,
    input  wire logic [2:0]  OUT_READY,
    input  wire logic [2:0]  RAIL_LOW,
    output logic      [7:0]  BUCK_A_CTRL,
    output logic      [7:0]  BUCK_B_CTRL,
    output logic      [7:0]  BUCK_C_CTRL,
    output logic      [2:0]  RAIL_RESET
);
    // Whole state in one struct
    typedef struct packed {
        buck_regs_pkg::ctrl_t    ctl_a;
        buck_regs_pkg::ctrl_t    ctl_b;
        buck_regs_pkg::ctrl_t    ctl_c;
        logic [23:0]             limits;
        logic [2:0]              rst_req;
        logic [31:0]             rdata;
        logic                    err;
        buck_regs_pkg::bus_st_t  st;
    } state_t;

    state_t cur_ff;
    state_t nxt_st;

    logic       setup;
    logic       access;
    logic [2:0] below;

    // Address map decode, used by the error check only; the read mux decodes PADDR itself
    function automatic logic mapped(input logic [11:0] a);
        case (a)
            `OFS_REG_A_CTRL, `OFS_REG_B_CTRL, `OFS_REG_C_CTRL,
            `OFS_PEAK_AB, `OFS_PEAK_C, `OFS_MAX_ON,
            `OFS_LOAD_A, `OFS_LOAD_B, `OFS_LOAD_C,
            `OFS_ALERT_A, `OFS_ALERT_B, `OFS_ALERT_C,
            `OFS_OUT_READY, `OFS_ZCAL_A, `OFS_ZCAL_B, `OFS_ZCAL_C,
            `OFS_LIMIT_CFG: mapped = 1'b1;
            default:        mapped = 1'b0;
        endcase
    endfunction

    // Writes only land on the writable words
    function automatic logic writable(input logic [11:0] a);
        writable = (a == `OFS_REG_A_CTRL) || (a == `OFS_REG_B_CTRL) ||
                   (a == `OFS_REG_C_CTRL) || (a == `OFS_LIMIT_CFG);
    endfunction

    assign setup  = PSEL && !PENABLE;
    assign access = PSEL && PENABLE;

    // One comparator per regulator output
    genvar gi;
    generate
        for (gi = 0; gi < 3; gi = gi + 1) begin : g_cmp
            logic [7:0] setting;
            assign setting = (gi == 0) ? cur_ff.ctl_a :
                             (gi == 1) ? cur_ff.ctl_b : cur_ff.ctl_c;
            pfail_cmp u_cmp (
                .setting (setting),
                .limit   (cur_ff.limits[gi*8 +: 8]),
                .below   (below[gi])
            );
        end
    endgenerate

    // Next-state logic; read data captured in setup so it is ready at access
    always_comb begin
        nxt_st         = cur_ff;
        nxt_st.rst_req = 3'h0;
        case (cur_ff.st)
            buck_regs_pkg::ST_IDLE: begin
                if (setup) begin
                    nxt_st.st  = buck_regs_pkg::ST_ACCESS;
                    nxt_st.err = !mapped(PADDR) ||
                                 (PWRITE && !writable(PADDR));
                    nxt_st.rdata = 32'h0000_0000;
                    if (!PWRITE) begin
                        case (PADDR)
                            `OFS_REG_A_CTRL: nxt_st.rdata =
                                {24'h000000, cur_ff.ctl_a};
                            `OFS_REG_B_CTRL: nxt_st.rdata =
                                {24'h000000, cur_ff.ctl_b};
                            `OFS_REG_C_CTRL: nxt_st.rdata =
                                {24'h000000, cur_ff.ctl_c};
                            `OFS_PEAK_AB:    nxt_st.rdata = `RST_PEAK_AB;
                            `OFS_PEAK_C:     nxt_st.rdata = `RST_PEAK_C;
                            `OFS_MAX_ON:     nxt_st.rdata = `RST_MAX_ON;
                            `OFS_OUT_READY:  nxt_st.rdata =
                                {29'h00000000, OUT_READY};
                            `OFS_LIMIT_CFG:  nxt_st.rdata =
                                {8'h00, cur_ff.limits};
                            default:         nxt_st.rdata = 32'h0000_0000;
                        endcase
                    end
                end
            end
            buck_regs_pkg::ST_ACCESS: begin
                nxt_st.st = buck_regs_pkg::ST_IDLE;
                // Reserved words refuse writes with an error, state unchanged
                if (access && PWRITE && !cur_ff.err && PSTRB[0]) begin
                    case (PADDR)
                        `OFS_REG_A_CTRL: nxt_st.ctl_a = PWDATA[7:0];
                        `OFS_REG_B_CTRL: nxt_st.ctl_b = PWDATA[7:0];
                        `OFS_REG_C_CTRL: nxt_st.ctl_c = PWDATA[7:0];
                        default: ;
                    endcase
                end
                if (access && PWRITE && !cur_ff.err &&
                    PADDR == `OFS_LIMIT_CFG) begin
                    if (PSTRB[0]) nxt_st.limits[7:0]   = PWDATA[7:0];
                    if (PSTRB[1]) nxt_st.limits[15:8]  = PWDATA[15:8];
                    if (PSTRB[2]) nxt_st.limits[23:16] = PWDATA[23:16];
                end
            end
            default: nxt_st.st = buck_regs_pkg::ST_IDLE;
        endcase
        // A low setting or a low monitored rail pulls the rail reset
        nxt_st.rst_req = below | RAIL_LOW;
    end

    // Monitored rail low: that domain's control word goes back to reset, its limit byte is kept
    always_ff @(posedge CLK or negedge RSTN) begin
        if (!RSTN) begin
            cur_ff.ctl_a   <= {`RST_RANGE, `RST_VSET_A};
            cur_ff.ctl_b   <= {`RST_RANGE, `RST_VSET_B};
            cur_ff.ctl_c   <= {`RST_RANGE, `RST_VSET_C};
            cur_ff.limits  <= {3{`RST_PFAIL_CODE}};
            cur_ff.rst_req <= 3'h0;
            cur_ff.rdata   <= 32'h0000_0000;
            cur_ff.err     <= 1'b0;
            cur_ff.st      <= buck_regs_pkg::ST_IDLE;
        end else begin
            cur_ff <= nxt_st;
            if (RAIL_LOW[0])
                cur_ff.ctl_a <= {`RST_RANGE, `RST_VSET_A};
            if (RAIL_LOW[1])
                cur_ff.ctl_b <= {`RST_RANGE, `RST_VSET_B};
            if (RAIL_LOW[2])
                cur_ff.ctl_c <= {`RST_RANGE, `RST_VSET_C};
        end
    end

    // Bus answers in the second cycle of every access
    assign PREADY      = (cur_ff.st == buck_regs_pkg::ST_ACCESS);
    assign PSLVERR     = PREADY && cur_ff.err;
    assign PRDATA      = cur_ff.rdata;
    assign BUCK_A_CTRL = cur_ff.ctl_a;
    assign BUCK_B_CTRL = cur_ff.ctl_b;
    assign BUCK_C_CTRL = cur_ff.ctl_c;
    assign RAIL_RESET  = cur_ff.rst_req;

    // Assertions
    property p_reset_a;
        @(posedge CLK) disable iff (!RSTN)
        $rose(RSTN) |-> BUCK_A_CTRL == 8'hf8;
    endproperty
    a_reset_a: assert property (p_reset_a) else $error("A reset bad");

    property p_write_a;
        @(posedge CLK) disable iff (!RSTN)
        (PREADY && PWRITE && !PSLVERR && PSTRB[0] && !RAIL_LOW[0] &&
         PADDR == `OFS_REG_A_CTRL) |=> BUCK_A_CTRL == $past(PWDATA[7:0]);
    endproperty
    a_write_a: assert property (p_write_a) else $error("A write lost");

    property p_write_b;
        @(posedge CLK) disable iff (!RSTN)
        (PREADY && PWRITE && !PSLVERR && PSTRB[0] && !RAIL_LOW[1] &&
         PADDR == `OFS_REG_B_CTRL) |=> BUCK_B_CTRL == $past(PWDATA[7:0]);
    endproperty
    a_write_b: assert property (p_write_b) else $error("B write lost");

    property p_rd_upper;
        @(posedge CLK) disable iff (!RSTN)
        (PREADY && !PWRITE && PADDR[11:4] == 8'h00) |-> PRDATA[31:8] == 0;
    endproperty
    a_rd_upper: assert property (p_rd_upper) else $error("Upper bits");

    property p_ready_rd;
        @(posedge CLK) disable iff (!RSTN)
        (setup && !PWRITE && PADDR == `OFS_OUT_READY) |=>
            PRDATA[2:0] == $past(OUT_READY);
    endproperty
    a_ready_rd: assert property (p_ready_rd) else $error("Ready rd");

    property p_low_rst;
        @(posedge CLK) disable iff (!RSTN)
        RAIL_LOW[1] |=> BUCK_B_CTRL == 8'hb2 && RAIL_RESET[1];
    endproperty
    a_low_rst: assert property (p_low_rst) else $error("Rail rst");

    property p_pfail;
        @(posedge CLK) disable iff (!RSTN)
        below[0] |=> RAIL_RESET[0];
    endproperty
    a_pfail: assert property (p_pfail) else $error("Fail rst");

    property p_ro_err;
        @(posedge CLK) disable iff (!RSTN)
        (setup && PWRITE && PADDR == `OFS_PEAK_AB) |=> PSLVERR;
    endproperty
    a_ro_err: assert property (p_ro_err) else $error("RO write ok");

    c_wr: cover property (@(posedge CLK) PREADY && PWRITE && !PSLVERR);
    c_rd: cover property (@(posedge CLK) PREADY && !PWRITE);
    c_err: cover property (@(posedge CLK) PSLVERR);
    c_rst: cover property (@(posedge CLK) |RAIL_RESET);
endmodule

//--- sim/buck_regulator_control_regs_tb_top.sv
// Self-checking bench for the buck regulator register bank
`timescale 1ns/1ns
`include "buck_regs_map.svh"
module buck_regulator_control_regs_tb_top;
    logic        clk = 1'b0;
    logic        rstn = 1'b0;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [3:0]  pstrb = 4'hf;
    logic [2:0]  out_ready = 3'h5;
    logic [2:0]  rail_low = 3'h0;
    logic [31:0] PRDATA;
    logic        PREADY;
    logic        PSLVERR;
    logic [7:0]  BUCK_A_CTRL;
    logic [7:0]  BUCK_B_CTRL;
    logic [7:0]  BUCK_C_CTRL;
    logic [2:0]  RAIL_RESET;
    logic [31:0] rd;
    logic        err;
    int          mismatches = 0;
    int          check_count = 0;

    buck_regulator_control_regs i_dut (.CLK(clk), .RSTN(rstn), .PSEL(psel),
        .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata),
        .PSTRB(pstrb), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
        .OUT_READY(out_ready), .RAIL_LOW(rail_low),
        .BUCK_A_CTRL(BUCK_A_CTRL), .BUCK_B_CTRL(BUCK_B_CTRL),
        .BUCK_C_CTRL(BUCK_C_CTRL), .RAIL_RESET(RAIL_RESET));

    // 250 MHz system clock
    always #2 clk = ~clk;

    // Verdict and end of run, shared by the main flow and timeouts
    task automatic close_out();
        $display("Checks %0d, mismatches %0d", check_count, mismatches);
        if (mismatches == 0 && check_count > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] seen,
                       input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            mismatches++;
            $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    // One APB transfer; pready, read data and error are all taken at
    // the rising edge that ends the access phase, then the bus is freed
    task automatic apb(input logic w, input logic [11:0] a,
                       input logic [31:0] d, input logic [3:0] s);
        int n;
        n = 0;
        @(posedge clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        pstrb <= s;
        @(posedge clk);
        penable <= 1'b1;
        do begin
            @(posedge clk);
            n++;
        end while (PREADY !== 1'b1 && n < 20);
        if (PREADY !== 1'b1) begin
            mismatches++;
            $display("CHECK FAILED pready expected 1 seen %b", PREADY);
            close_out();
        end else begin
            rd = PRDATA;
            err = PSLVERR;
            psel <= 1'b0;
            penable <= 1'b0;
        end
    endtask

    task automatic rdchk(input string nm, input logic [11:0] a,
                         input logic [31:0] exp);
        apb(1'b0, a, 32'h0000_0000, 4'hf);
        chk(nm, rd, exp);
    endtask

    // Bounded wait for the rail reset outputs to settle
    task automatic wait_rr(input logic [2:0] exp);
        int n;
        n = 0;
        while (RAIL_RESET !== exp && n < 8) begin
            @(negedge clk);
            n++;
        end
        chk("rail_reset", {29'h0, RAIL_RESET}, {29'h0, exp});
    endtask

    initial begin
        repeat (6) @(posedge clk);
        chk("a_ctrl_in_reset", {24'h0, BUCK_A_CTRL}, 32'hf8);
        rstn <= 1'b1;
        rdchk("a_reset", `OFS_REG_A_CTRL, 32'hf8);
        rdchk("b_reset", `OFS_REG_B_CTRL, 32'hb2);
        rdchk("c_reset", `OFS_REG_C_CTRL, 32'hb2);
        rdchk("ready_status", `OFS_OUT_READY, 32'h5);
        $display("Test reset_values done");
        // Reserved upper bits are dropped, range and code land
        apb(1'b1, `OFS_REG_A_CTRL, 32'hffff_ff05, 4'hf);
        chk("a_write_ok", {31'h0, err}, 32'h0);
        @(negedge clk);
        chk("a_ctrl_out", {24'h0, BUCK_A_CTRL}, 32'h05);
        rdchk("a_readback", `OFS_REG_A_CTRL, 32'h05);
        apb(1'b1, `OFS_REG_B_CTRL, 32'h0000_0080, 4'hf);
        rdchk("b_readback", `OFS_REG_B_CTRL, 32'h80);
        apb(1'b1, `OFS_REG_C_CTRL, 32'h0000_007f, 4'he);
        rdchk("c_no_strobe", `OFS_REG_C_CTRL, 32'hb2);
        chk("c_ctrl_out", {24'h0, BUCK_C_CTRL}, 32'hb2);
        $display("Test control_writes done");
        // Read-only words refuse writes; an unmapped read answers with an error
        apb(1'b1, `OFS_PEAK_AB, 32'h0000_0000, 4'hf);
        chk("ro_write_err", {31'h0, err}, 32'h1);
        rdchk("ro_unchanged", `OFS_PEAK_AB, 32'h88);
        rdchk("peak_c_value", `OFS_PEAK_C, 32'h8);
        rdchk("max_on_value", `OFS_MAX_ON, 32'h8);
        apb(1'b1, `OFS_OUT_READY, 32'h0000_0000, 4'hf);
        chk("status_write_err", {31'h0, err}, 32'h1);
        rdchk("status_kept", `OFS_OUT_READY, 32'h5);
        apb(1'b0, 12'h010, 32'h0000_0000, 4'hf);
        chk("unmapped_err", {31'h0, err}, 32'h1);
        $display("Test refusals done");
        // Code 5 with range 0 is level 5: limit 5 is not below, 6 is
        apb(1'b1, `OFS_LIMIT_CFG, 32'h0000_0005, 4'hf);
        repeat (3) @(negedge clk);
        chk("no_fail_at_limit", {29'h0, RAIL_RESET}, 32'h0);
        apb(1'b1, `OFS_LIMIT_CFG, 32'h0000_0006, 4'hf);
        wait_rr(3'h1);
        apb(1'b1, `OFS_LIMIT_CFG, 32'h0000_0000, 4'hf);
        wait_rr(3'h0);
        $display("Test fail_level done");
        // A low rail resets only its own regulator's control word
        apb(1'b1, `OFS_REG_B_CTRL, 32'h0000_0011, 4'hf);
        @(posedge clk);
        rail_low <= 3'h2;
        repeat (2) @(negedge clk);
        chk("rail_b_reset", {29'h0, RAIL_RESET}, 32'h2);
        chk("b_ctrl_low", {24'h0, BUCK_B_CTRL}, 32'hb2);
        chk("a_ctrl_kept", {24'h0, BUCK_A_CTRL}, 32'h05);
        @(posedge clk);
        rail_low <= 3'h0;
        rdchk("b_after_low", `OFS_REG_B_CTRL, 32'hb2);
        // Second reset in mid-run restores defaults
        @(posedge clk);
        rstn <= 1'b0;
        @(negedge clk);
        chk("a_ctrl_rereset", {24'h0, BUCK_A_CTRL}, 32'hf8);
        @(posedge clk);
        rstn <= 1'b1;
        rdchk("a_after_rereset", `OFS_REG_A_CTRL, 32'hf8);
        rdchk("limit_after_rereset", `OFS_LIMIT_CFG, 32'h0);
        chk("rail_after_rereset", {29'h0, RAIL_RESET}, 32'h0);
        $display("Test rail_low done");
        close_out();
    end
endmodule
